/* File: sdpr_consts.svh */
// constants for the synchronous dual-port ram block
`ifndef SDPR_CONSTS_SVH
`define SDPR_CONSTS_SVH

`define SDPR_DATA_W 18
`define SDPR_ADDR_W 15
`define SDPR_DEPTH 32768
`define SDPR_UPPER_MSB 17
`define SDPR_UPPER_LSB 9
`define SDPR_LOWER_MSB 8
`define SDPR_LOWER_LSB 0
`define SDPR_LANE_UPPER 1
`define SDPR_LANE_LOWER 0
`define SDPR_NUM_PORTS 2
`define SDPR_COUNTER_RESET_ADDR 15'h0000
`define SDPR_COUNTER_STEP 15'h0001
`define SDPR_CLK_PERIOD_NS 20
`define SDPR_PIPE_EXTRA_CYCLES 1

`endif

/* File: sdpr_pkg.sv */
// types shared by the dual-port ram block
`include "sdpr_consts.svh"

package sdpr_pkg;

  typedef logic [`SDPR_ADDR_W-1:0] sdpr_addr_t;
  typedef logic [`SDPR_DATA_W-1:0] sdpr_data_t;
  typedef logic [1:0] sdpr_lanes_t;

  // synchronous inputs of one port, sampled on the clock edge
  typedef struct packed {
    logic chip_select_active_low;
    logic chip_select_active_high;
    logic upper_byte_select_n;
    logic lower_byte_select_n;
    logic read_write;
    logic address_load_strobe_n;
    logic counter_advance_n;
    logic counter_clear_n;
    logic output_latency_select;
    sdpr_addr_t port_address;
    sdpr_data_t write_data;
  } sdpr_port_in_s;

  // registered outputs of one port
  typedef struct packed {
    sdpr_data_t read_data;
    sdpr_lanes_t lane_drive;
    logic standby;
  } sdpr_port_out_s;

  // one write request toward the array
  typedef struct packed {
    sdpr_addr_t addr;
    sdpr_data_t data;
    sdpr_lanes_t lanes;
  } sdpr_wr_s;

endpackage

/* File: sdpr_mem_array.sv */
// flip-flop storage array with two independent write and read ports
`timescale 1ns/1ns
`default_nettype none
`include "sdpr_consts.svh"

module sdpr_mem_array #(
  parameter int DEPTH = `SDPR_DEPTH
) (
  input wire logic clk,
  input wire sdpr_pkg::sdpr_wr_s wr_left,
  input wire sdpr_pkg::sdpr_wr_s wr_right,
  input wire sdpr_pkg::sdpr_addr_t rd_addr_left,
  input wire sdpr_pkg::sdpr_addr_t rd_addr_right,
  output sdpr_pkg::sdpr_data_t rd_data_left,
  output sdpr_pkg::sdpr_data_t rd_data_right
);

  sdpr_pkg::sdpr_data_t mem [DEPTH];

  function automatic sdpr_pkg::sdpr_data_t merge_lanes(
    input sdpr_pkg::sdpr_data_t old_word,
    input sdpr_pkg::sdpr_wr_s req
  );
    sdpr_pkg::sdpr_data_t word;
    word = old_word;
    if (req.lanes[`SDPR_LANE_UPPER]) begin
      word[`SDPR_UPPER_MSB:`SDPR_UPPER_LSB] = req.data[`SDPR_UPPER_MSB:`SDPR_UPPER_LSB];
    end
    if (req.lanes[`SDPR_LANE_LOWER]) begin
      word[`SDPR_LOWER_MSB:`SDPR_LOWER_LSB] = req.data[`SDPR_LOWER_MSB:`SDPR_LOWER_LSB];
    end
    return word;
  endfunction

  // both ports may hit one word; right port lands last on a true collision
  always_ff @(posedge clk) begin
    if (wr_left.lanes != 2'h0) begin
      mem[wr_left.addr] <= merge_lanes(mem[wr_left.addr], wr_left);
    end
    if (wr_right.lanes != 2'h0) begin
      if ((wr_left.lanes != 2'h0) && (wr_left.addr == wr_right.addr)) begin
        mem[wr_right.addr] <= merge_lanes(merge_lanes(mem[wr_right.addr], wr_left), wr_right);
      end else begin
        mem[wr_right.addr] <= merge_lanes(mem[wr_right.addr], wr_right);
      end
    end
  end

  assign rd_data_left = mem[rd_addr_left];
  assign rd_data_right = mem[rd_addr_right];

endmodule
`default_nettype wire

/* File: sdpr_dual_port_ram.sv */
// two-port synchronous ram: input registers, address counters, output staging
`timescale 1ns/1ns
`default_nettype none
`include "sdpr_consts.svh"

module sdpr_dual_port_ram #(
  parameter int ADDR_W = `SDPR_ADDR_W,
  parameter int DEPTH = `SDPR_DEPTH,
  parameter int PORTS = `SDPR_NUM_PORTS
) (
  input wire logic clk,
  input wire logic reset,
  input wire sdpr_pkg::sdpr_port_in_s left_in,
  input wire sdpr_pkg::sdpr_port_in_s right_in,
  input wire logic left_output_enable_n,
  input wire logic right_output_enable_n,
  output sdpr_pkg::sdpr_data_t left_port_data_lanes,
  output logic [1:0] left_lane_oe,
  output logic left_standby,
  output sdpr_pkg::sdpr_data_t right_port_data_lanes,
  output logic [1:0] right_lane_oe,
  output logic right_standby
);

  sdpr_pkg::sdpr_port_in_s port_in [PORTS];
  sdpr_pkg::sdpr_port_in_s ctrl_q [PORTS];
  sdpr_pkg::sdpr_addr_t counter [PORTS];
  sdpr_pkg::sdpr_addr_t next_counter [PORTS];
  sdpr_pkg::sdpr_wr_s wr_req [PORTS];
  sdpr_pkg::sdpr_data_t rd_word [PORTS];
  sdpr_pkg::sdpr_data_t stage_data [PORTS];
  sdpr_pkg::sdpr_lanes_t stage_lanes [PORTS];
  sdpr_pkg::sdpr_port_out_s port_out [PORTS];
  sdpr_pkg::sdpr_port_out_s next_port_out [PORTS];
  logic [PORTS-1:0] oe_n;

  function automatic logic port_selected(input sdpr_pkg::sdpr_port_in_s c);
    return !c.chip_select_active_low && c.chip_select_active_high;
  endfunction

  // lane bit set means the byte select of that lane is low
  function automatic sdpr_pkg::sdpr_lanes_t lanes_active(input sdpr_pkg::sdpr_port_in_s c);
    sdpr_pkg::sdpr_lanes_t l;
    l = 2'h0;
    if (port_selected(c)) begin
      l[`SDPR_LANE_UPPER] = !c.upper_byte_select_n;
      l[`SDPR_LANE_LOWER] = !c.lower_byte_select_n;
    end
    return l;
  endfunction

  always_comb begin
    port_in[0] = left_in;
    port_in[1] = right_in;
    oe_n[0] = left_output_enable_n;
    oe_n[1] = right_output_enable_n;
  end

  // counter source priority: clear, then strobe load, then advance, else hold
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      if (!port_in[p].counter_clear_n) begin
        next_counter[p] = `SDPR_COUNTER_RESET_ADDR;
      end else if (!port_in[p].address_load_strobe_n) begin
        next_counter[p] = port_in[p].port_address;
      end else if (!port_in[p].counter_advance_n) begin
        next_counter[p] = counter[p] + `SDPR_COUNTER_STEP;
      end else begin
        next_counter[p] = counter[p];
      end
    end
  end

  // counter doubles as the address input register, one per port
  always_ff @(posedge clk) begin
    for (int p = 0; p < PORTS; p++) begin
      if (reset) begin
        counter[p] <= `SDPR_COUNTER_RESET_ADDR;
      end else begin
        counter[p] <= next_counter[p];
      end
    end
  end

  // data and control input registers
  always_ff @(posedge clk) begin
    for (int p = 0; p < PORTS; p++) begin
      if (reset) begin
        ctrl_q[p] <= '0;
        ctrl_q[p].chip_select_active_low <= 1'b1;
        ctrl_q[p].read_write <= 1'b1;
        ctrl_q[p].upper_byte_select_n <= 1'b1;
        ctrl_q[p].lower_byte_select_n <= 1'b1;
        ctrl_q[p].address_load_strobe_n <= 1'b1;
        ctrl_q[p].counter_advance_n <= 1'b1;
        ctrl_q[p].counter_clear_n <= 1'b1;
      end else begin
        ctrl_q[p] <= port_in[p];
      end
    end
  end

  // write requests from the registered access, committed on the next edge
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      wr_req[p].addr = counter[p];
      wr_req[p].data = ctrl_q[p].write_data;
      if (!ctrl_q[p].read_write) begin
        wr_req[p].lanes = lanes_active(ctrl_q[p]);
      end else begin
        wr_req[p].lanes = 2'h0;
      end
    end
  end

  sdpr_mem_array #(
    .DEPTH(DEPTH)
  ) u_array (
    .clk(clk),
    .wr_left(wr_req[0]),
    .wr_right(wr_req[1]),
    .rd_addr_left(counter[0]),
    .rd_addr_right(counter[1]),
    .rd_data_left(rd_word[0]),
    .rd_data_right(rd_word[1])
  );

  // read side: flow-through takes the array word now, pipelined one stage later
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      next_port_out[p].standby = !port_selected(ctrl_q[p]);
      if (ctrl_q[p].output_latency_select) begin
        next_port_out[p].read_data = stage_data[p];
        next_port_out[p].lane_drive = stage_lanes[p];
      end else begin
        next_port_out[p].read_data = rd_word[p];
        if (ctrl_q[p].read_write) begin
          next_port_out[p].lane_drive = lanes_active(ctrl_q[p]);
        end else begin
          next_port_out[p].lane_drive = 2'h0;
        end
      end
    end
  end

  // extra stage used by the pipelined mode
  always_ff @(posedge clk) begin
    for (int p = 0; p < PORTS; p++) begin
      if (reset) begin
        stage_data[p] <= '0;
        stage_lanes[p] <= 2'h0;
      end else begin
        stage_data[p] <= rd_word[p];
        if (ctrl_q[p].read_write) begin
          stage_lanes[p] <= lanes_active(ctrl_q[p]);
        end else begin
          stage_lanes[p] <= 2'h0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int p = 0; p < PORTS; p++) begin
      if (reset) begin
        port_out[p].read_data <= '0;
        port_out[p].lane_drive <= 2'h0;
        port_out[p].standby <= 1'b1;
      end else begin
        port_out[p] <= next_port_out[p];
      end
    end
  end

  assign left_port_data_lanes = port_out[0].read_data;
  assign right_port_data_lanes = port_out[1].read_data;
  assign left_standby = port_out[0].standby;
  assign right_standby = port_out[1].standby;

  // output enable gates the lane drivers without waiting for a clock edge
  assign left_lane_oe = port_out[0].lane_drive & {2{!oe_n[0]}};
  assign right_lane_oe = port_out[1].lane_drive & {2{!oe_n[1]}};

endmodule
`default_nettype wire

/* File: sdpr_chk.sv */
// assertion checker for the dual-port ram ports
`timescale 1ns/1ns
`default_nettype none
module sdpr_chk (
  input wire logic clk,
  input wire logic reset,
  input wire sdpr_pkg::sdpr_port_in_s left_in,
  input wire sdpr_pkg::sdpr_port_in_s right_in,
  input wire logic left_output_enable_n,
  input wire logic right_output_enable_n,
  input wire logic [1:0] left_lane_oe,
  input wire logic left_standby,
  input wire logic [1:0] right_lane_oe,
  input wire logic right_standby
);
  logic lsel;
  logic rsel;
  assign lsel = !left_in.chip_select_active_low && left_in.chip_select_active_high;
  assign rsel = !right_in.chip_select_active_low && right_in.chip_select_active_high;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  left_oe_float_a: assert property (left_output_enable_n |-> left_lane_oe == 2'h0)
    else $error("left lanes driven while output enable off");
  right_oe_float_a: assert property (right_output_enable_n |-> right_lane_oe == 2'h0)
    else $error("right lanes driven while output enable off");
  // inputs sampled at one edge show on the outputs after the next edge, pipelined read data and lanes one edge later
  desel_standby_a: assert property (!lsel |-> ##2 left_standby)
    else $error("deselected port not in standby");
  sel_awake_a: assert property (rsel |-> ##2 !right_standby)
    else $error("selected port left in standby");
  desel_float_a: assert property ((!lsel && !left_in.output_latency_select) |-> ##2 left_lane_oe == 2'h0)
    else $error("deselected port drives lanes");
  write_float_a: assert property ((lsel && !left_in.read_write && !left_in.output_latency_select)
    |-> ##2 left_lane_oe == 2'h0) else $error("write cycle drives lanes");
  read_lanes_a: assert property ((lsel && left_in.read_write && !left_in.output_latency_select)
    ##2 !left_output_enable_n |-> left_lane_oe == ~$past({left_in.upper_byte_select_n,
    left_in.lower_byte_select_n}, 2)) else $error("flow read lane enables wrong");
  pipe_lanes_a: assert property ((lsel && left_in.read_write && left_in.output_latency_select)
    ##1 left_in.output_latency_select ##2 !left_output_enable_n |-> left_lane_oe ==
    ~$past({left_in.upper_byte_select_n, left_in.lower_byte_select_n}, 3)) else $error("pipelined lanes wrong");
endmodule
bind sdpr_dual_port_ram sdpr_chk i_sdpr_chk (.clk(clk), .reset(reset), .left_in(left_in), .right_in(right_in),
  .left_output_enable_n(left_output_enable_n), .right_output_enable_n(right_output_enable_n),
  .left_lane_oe(left_lane_oe), .left_standby(left_standby), .right_lane_oe(right_lane_oe),
  .right_standby(right_standby));
`default_nettype wire

/* File: sdpr_ctrl_model.sv */
// bus master model that presents one port's synchronous inputs
`timescale 1ns/1ns
`default_nettype none
module sdpr_ctrl_model (
  input wire sdpr_pkg::sdpr_port_in_s cmd,
  output sdpr_pkg::sdpr_port_in_s port
);
  always_comb begin
    port = cmd;
    if (!cmd.address_load_strobe_n) begin
      port.read_write = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking testbench for the dual-port ram
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [2:0] LD = 3'h3;
  localparam logic [2:0] HOLD = 3'h7;
  localparam logic [2:0] ADV = 3'h5;
  localparam logic [2:0] CLR = 3'h6;
  localparam sdpr_pkg::sdpr_port_in_s IDLE = {2'h2, 2'h3, 1'b1, 3'h7, 1'b0, 15'h0, 18'h0};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic loe = 1'b0;
  logic roe = 1'b0;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  sdpr_pkg::sdpr_port_in_s cl = IDLE;
  sdpr_pkg::sdpr_port_in_s cr = IDLE;
  sdpr_pkg::sdpr_port_in_s pl, pr;
  sdpr_pkg::sdpr_data_t ld, rd;
  logic [1:0] lo, ro;
  logic ls, rs;
  always #10 clk = ~clk;
  sdpr_ctrl_model i_sdpr_ctrl_model_l (.cmd(cl), .port(pl));
  sdpr_ctrl_model i_sdpr_ctrl_model_r (.cmd(cr), .port(pr));
  sdpr_dual_port_ram i_sdpr_dual_port_ram (.clk(clk), .reset(reset), .left_in(pl), .right_in(pr),
    .left_output_enable_n(loe), .right_output_enable_n(roe), .left_port_data_lanes(ld), .left_lane_oe(lo),
    .left_standby(ls), .right_port_data_lanes(rd), .right_lane_oe(ro), .right_standby(rs));
  function automatic sdpr_pkg::sdpr_port_in_s mk(input int s, input logic [1:0] b, input int w,
    input logic [2:0] c, input int p, input logic [14:0] a, input logic [17:0] d);
    return {~s[0], s[0], b, w[0], c, p[0], a, d};
  endfunction
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic put(input sdpr_pkg::sdpr_port_in_s x);
    @(posedge clk);
    cl <= x;
  endtask
  task automatic get(input logic [17:0] e, input logic [1:0] o, input logic [17:0] m);
    put(IDLE);
    @(posedge clk);
    #1;
    chk(ld & m, e);
    chk({16'h0, lo}, {16'h0, o});
  endtask
  task automatic t_write_read;
    put(mk(1, 2'h0, 1, LD, 0, 15'h7FFF, 18'h0));
    put(mk(1, 2'h0, 0, HOLD, 0, 15'h0123, 18'h2A5A5));
    put(mk(1, 2'h0, 1, HOLD, 0, 15'h0456, 18'h0));
    get(18'h2A5A5, 2'h3, 18'h3FFFF);
  endtask
  task automatic t_lanes;
    put(mk(1, 2'h1, 0, HOLD, 0, 15'h0, 18'h3FFFF));
    put(mk(1, 2'h2, 1, HOLD, 0, 15'h0, 18'h0));
    get(18'h001A5, 2'h1, 18'h001FF);
    put(mk(1, 2'h0, 1, HOLD, 0, 15'h0, 18'h0));
    get(18'h3FFA5, 2'h3, 18'h3FFFF);
    put(mk(1, 2'h3, 1, HOLD, 0, 15'h0, 18'h0));
    get(18'h0, 2'h0, 18'h0);
  endtask
  task automatic t_counter;
    put(mk(1, 2'h0, 0, CLR, 0, 15'h1234, 18'h11111));
    put(mk(0, 2'h3, 1, LD, 0, 15'h7FFE, 18'h0));
    put(mk(0, 2'h3, 1, ADV, 0, 15'h0, 18'h0));
    put(mk(1, 2'h0, 1, ADV, 0, 15'h0055, 18'h0));
    get(18'h11111, 2'h3, 18'h3FFFF);
  endtask
  task automatic t_pipe;
    put(mk(1, 2'h0, 1, LD, 1, 15'h7FFF, 18'h0));
    put(mk(0, 2'h3, 1, HOLD, 1, 15'h0, 18'h0));
    @(posedge clk);
    #1;
    chk({16'h0, lo}, 18'h0);
    @(posedge clk);
    #1;
    chk(ld, 18'h3FFA5);
    chk({16'h0, lo}, 18'h3);
    put(IDLE);
  endtask
  task automatic t_oe;
    put(mk(1, 2'h0, 1, LD, 0, 15'h7FFF, 18'h0));
    repeat (2) @(posedge clk);
    #1;
    chk({16'h0, lo}, 18'h3);
    @(posedge clk);
    loe <= 1'b1;
    roe <= 1'b1;
    #1;
    chk({16'h0, lo}, 18'h0);
    @(posedge clk);
    loe <= 1'b0;
    roe <= 1'b0;
    cl <= IDLE;
    repeat (2) @(posedge clk);
    #1;
    chk({17'h0, ls}, 18'h1);
  endtask
  task automatic t_right;
    @(posedge clk);
    cr <= mk(1, 2'h0, 1, LD, 0, 15'h0, 18'h0);
    cl <= mk(1, 2'h0, 1, LD, 0, 15'h0, 18'h0);
    @(posedge clk);
    cr <= mk(1, 2'h0, 0, HOLD, 0, 15'h0, 18'h15555);
    @(posedge clk);
    cr <= IDLE;
    #1;
    chk(ld, 18'h11111);
    chk(rd, 18'h11111);
    chk({16'h0, ro}, 18'h3);
    chk({17'h0, rs}, 18'h0);
    repeat (2) @(posedge clk);
    cl <= IDLE;
    #1;
    chk(ld, 18'h15555);
  endtask
  // mid-run reset: outputs idle, counter back at zero
  task automatic t_reset;
    put(mk(1, 2'h0, 1, LD, 0, 15'h7FFF, 18'h0));
    @(posedge clk);
    reset <= 1'b1;
    cl <= mk(1, 2'h0, 1, HOLD, 0, 15'h0, 18'h0);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk(ld, 18'h0);
    chk({16'h0, lo}, 18'h0);
    chk({17'h0, ls}, 18'h1);
    repeat (2) @(posedge clk);
    cl <= IDLE;
    #1;
    chk(ld, 18'h15555);
  endtask
  task automatic print_verdict;
    $display("errors=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_write_read;
    t_lanes;
    t_counter;
    t_pipe;
    t_oe;
    t_right;
    t_reset;
    print_verdict;
  end
endmodule
`default_nettype wire
